// file: lar_defines.svh
// Notes on behaviour
// - Channel 0 result at 14h low, 15h high
// - Channel 1 result at 16h low, 17h high
// - Result bytes read-only, reset to 00h
// - Word read returns low and high together
// - Host reads low byte before high byte
// - Low-byte read latches high byte into shadow
// - Later conversions leave shadowed high byte intact
// - Manual integration counted in 10.9 us steps
// - Duration count 16 bits at 18h/19h
// - Host keeps manual integrations under 714.3 ms
// - Duration bytes reset to 00h
// - Register 1Eh bit 7 part flag, rest reserved
// - Host should not write register 1Eh
`ifndef LAR_DEFINES_SVH
`define LAR_DEFINES_SVH
`define LAR_ADDR_CH0_LOW     8'h14
`define LAR_ADDR_CH0_HIGH    8'h15
`define LAR_ADDR_CH1_LOW     8'h16
`define LAR_ADDR_CH1_HIGH    8'h17
`define LAR_ADDR_DUR_LOW     8'h18
`define LAR_ADDR_DUR_HIGH    8'h19
`define LAR_ADDR_PART_FLAG   8'h1E
`define LAR_RESULT_RESET     8'h00
`define LAR_DUR_RESET        16'h0000
`define LAR_PART_FLAG_BIT    7
`define LAR_PART_RSVD_RESET  7'h00
`define LAR_CLK_PERIOD_PS    100000
`define LAR_STEP_PS          10900000
`define LAR_STEP_CYCLES      (`LAR_STEP_PS / `LAR_CLK_PERIOD_PS)
`define LAR_MAX_MANUAL_US    714300
`endif

// file: lar_pkg.sv
package lar_pkg;
  typedef logic [7:0] lar_byte_t;
  typedef enum logic [1:0] {
    LAR_ACC_IDLE,
    LAR_ACC_BYTE,
    LAR_ACC_WORD
  } lar_acc_t;
endpackage

// file: lar_if.sv
`timescale 1ns/1ps
interface lar_if;
  import lar_pkg::*;
  logic        req;
  logic        we;
  logic        word;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        ack;
  logic [15:0] rdata;
  modport dev  (input req, we, word, addr, wdata, output ack, rdata);
  modport host (output req, we, word, addr, wdata, input ack, rdata);
endinterface

// file: lar_device.sv
`timescale 1ns/1ps
`include "lar_defines.svh"
module lar_device
  import lar_pkg::*;
#(
  parameter int   STEP_CYCLES     = `LAR_STEP_CYCLES,
  // Part flag value is arbitrary
  parameter logic PART_FLAG_VALUE = 1'h0
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  lar_if.dev               bus,
  input  wire logic        i_conv_done,
  input  wire logic [15:0] i_chan0_value,
  input  wire logic [15:0] i_chan1_value,
  input  wire logic        i_manual_run,
  output logic             o_manual_busy
);
  logic [15:0] chan0_q;
  logic [15:0] chan1_q;
  lar_byte_t   shadow0_q;
  lar_byte_t   shadow1_q;
  logic [15:0] dur_q;
  logic [15:0] step_cnt_q;
  lar_byte_t   part_q;
  logic        run_q;
  logic        ack_q;
  logic [15:0] rdata_q;
  logic        rd;
  logic        run_start;
  logic [15:0] step_base;
  logic [15:0] dur_base;

  // Byte read selector, shared by byte and word accesses
  function automatic lar_byte_t rd_byte(input logic [7:0] a);
    case (a)
      `LAR_ADDR_CH0_LOW:   rd_byte = chan0_q[7:0];
      `LAR_ADDR_CH0_HIGH:  rd_byte = shadow0_q;
      `LAR_ADDR_CH1_LOW:   rd_byte = chan1_q[7:0];
      `LAR_ADDR_CH1_HIGH:  rd_byte = shadow1_q;
      `LAR_ADDR_DUR_LOW:   rd_byte = dur_q[7:0];
      `LAR_ADDR_DUR_HIGH:  rd_byte = dur_q[15:8];
      `LAR_ADDR_PART_FLAG: rd_byte = part_q;
      default:             rd_byte = 8'h00;
    endcase
  endfunction

  assign rd = bus.req && !bus.we;

  // Conversion results; no write path
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      chan0_q <= {`LAR_RESULT_RESET, `LAR_RESULT_RESET};
      chan1_q <= {`LAR_RESULT_RESET, `LAR_RESULT_RESET};
    end else if (i_conv_done) begin
      chan0_q <= i_chan0_value;
      chan1_q <= i_chan1_value;
    end
  end

  // Shadow of high bytes caught on low-byte reads
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      shadow0_q <= `LAR_RESULT_RESET;
      shadow1_q <= `LAR_RESULT_RESET;
    end else if (rd) begin
      if (bus.addr == `LAR_ADDR_CH0_LOW)
        shadow0_q <= chan0_q[15:8];
      if (bus.addr == `LAR_ADDR_CH1_LOW)
        shadow1_q <= chan1_q[15:8];
    end
  end

  // Run start counts as first cycle of a fresh step
  always_comb begin
    run_start = i_manual_run && !run_q;
    step_base = run_start ? 16'h0000 : step_cnt_q;
    dur_base  = run_start ? `LAR_DUR_RESET : dur_q;
  end

  // Manual integration step timer and duration count
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      run_q      <= 1'b0;
      step_cnt_q <= 16'h0000;
      dur_q      <= `LAR_DUR_RESET;
    end else begin
      run_q <= i_manual_run;
      if (i_manual_run) begin
        if (step_base == 16'(STEP_CYCLES - 1)) begin
          step_cnt_q <= 16'h0000;
          dur_q      <= dur_base + 16'h0001;
        end else begin
          step_cnt_q <= step_base + 16'h0001;
          dur_q      <= dur_base;
        end
      end
    end
  end

  // Part flag register, writable though not advised
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset)
      part_q <= {PART_FLAG_VALUE, `LAR_PART_RSVD_RESET};
    else if (bus.req && bus.we && bus.addr == `LAR_ADDR_PART_FLAG)
      part_q <= bus.wdata;
  end

  // Read answer, one cycle after request
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ack_q   <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      ack_q <= bus.req;
      if (rd && bus.word) begin
        // Word read returns low byte and live high byte
        case (bus.addr)
          `LAR_ADDR_CH0_LOW: rdata_q <= chan0_q;
          `LAR_ADDR_CH1_LOW: rdata_q <= chan1_q;
          default: rdata_q <= {rd_byte(bus.addr + 8'h01), rd_byte(bus.addr)};
        endcase
      end else if (rd) begin
        rdata_q <= {8'h00, rd_byte(bus.addr)};
      end
    end
  end

  assign bus.ack   = ack_q;
  assign bus.rdata = rdata_q;
  assign o_manual_busy = run_q;
endmodule

// file: lar_host.sv
`timescale 1ns/1ps
`include "lar_defines.svh"
module lar_host
  import lar_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  lar_if.host              bus,
  input  wire logic        i_start,
  input  wire logic        i_word,
  input  wire logic [7:0]  i_addr,
  output logic             o_busy,
  output logic             o_done,
  output logic [15:0]      o_data
);
  lar_acc_t    st_q;
  logic        req_q;
  logic        word_q;
  logic [7:0]  addr_q;
  logic        done_q;
  logic [15:0] data_q;
  logic        busy_q;

  // Read sequencer; result high-byte byte reads (15h/17h) go low first
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      st_q   <= LAR_ACC_IDLE;
      req_q  <= 1'b0;
      word_q <= 1'b0;
      addr_q <= 8'h00;
      done_q <= 1'b0;
      data_q <= 16'h0000;
      busy_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      req_q  <= 1'b0;
      case (st_q)
        LAR_ACC_IDLE: begin
          if (i_start) begin
            busy_q <= 1'b1;
            req_q  <= 1'b1;
            word_q <= i_word;
            if (!i_word && (i_addr == `LAR_ADDR_CH0_HIGH ||
                            i_addr == `LAR_ADDR_CH1_HIGH)) begin
              addr_q <= i_addr - 8'h01;
              st_q   <= LAR_ACC_BYTE;
            end else begin
              addr_q <= i_addr;
              st_q   <= LAR_ACC_WORD;
            end
          end
        end
        LAR_ACC_BYTE: begin
          if (bus.ack) begin
            req_q  <= 1'b1;
            addr_q <= addr_q + 8'h01;
            st_q   <= LAR_ACC_WORD;
          end
        end
        LAR_ACC_WORD: begin
          if (bus.ack) begin
            data_q <= bus.rdata;
            done_q <= 1'b1;
            busy_q <= 1'b0;
            st_q   <= LAR_ACC_IDLE;
          end
        end
        default: st_q <= LAR_ACC_IDLE;
      endcase
    end
  end

  assign bus.req   = req_q;
  assign bus.we    = 1'b0;
  assign bus.word  = word_q;
  assign bus.addr  = addr_q;
  assign bus.wdata = 8'h00;
  assign o_busy    = busy_q;
  assign o_done    = done_q;
  assign o_data    = data_q;
endmodule

// file: lar_assertions.sv
`timescale 1ns/1ps
module lar_assertions #(
  parameter logic PART_FLAG_VALUE = 1'h0
) (
  input wire logic        i_clk_sys,
  input wire logic        i_reset,
  input wire logic        req,
  input wire logic        we,
  input wire logic        word,
  input wire logic [7:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        ack,
  input wire logic [15:0] rdata
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  // Read request on the bus
  sequence s_rd;
    req && !we;
  endsequence
  property p_ack; s_rd |=> ack; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_cause; ack |-> $past(req); endproperty
  a_cause: assert property (p_cause) else $error("ack alone");
  property p_pulse; ack |=> !ack; endproperty
  a_pulse: assert property (p_pulse) else $error("ack long");
  property p_hold; !$past(req) |-> $stable(rdata); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_flag;
    s_rd ##0 !word && addr == 8'h1E
      |=> rdata[7:0] == {PART_FLAG_VALUE, 7'h00};
  endproperty
  a_flag: assert property (p_flag) else $error("flag value");
  property p_lo;
    s_rd ##0 !word && (addr == 8'h15 || addr == 8'h17)
      |-> $past(addr, 2) == addr - 8'h01;
  endproperty
  a_lo: assert property (p_lo) else $error("high before low");
  property p_nowr; req && we |-> addr != 8'h1E; endproperty
  a_nowr: assert property (p_nowr) else $error("flag written");
  property p_unmap; s_rd ##0 addr == 8'h20 |=> rdata == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
endmodule

// file: light_adc_result_readout_tb_top.sv
`timescale 1ns/1ps
module light_adc_result_readout_tb_top;
  localparam int STEP = 2;
  // Part flag value is arbitrary
  localparam logic PART_FLAG = 1'h0;
  logic        clk, rst, start, wsel, conv, run, busy, done, mbusy;
  logic [7:0]  adr;
  logic [15:0] v0, v1, data, d;
  int          checks, miscompares;
  lar_if lar_if_inst ();
  lar_device #(.STEP_CYCLES(STEP), .PART_FLAG_VALUE(PART_FLAG))
    lar_device_inst (.i_clk_sys(clk),
    .i_reset(rst), .bus(lar_if_inst), .i_conv_done(conv),
    .i_chan0_value(v0), .i_chan1_value(v1), .i_manual_run(run),
    .o_manual_busy(mbusy));
  lar_host lar_host_inst (.i_clk_sys(clk), .i_reset(rst),
    .bus(lar_if_inst), .i_start(start), .i_word(wsel), .i_addr(adr),
    .o_busy(busy), .o_done(done), .o_data(data));
  lar_assertions #(.PART_FLAG_VALUE(PART_FLAG)) lar_assertions_inst (
    .i_clk_sys(clk), .i_reset(rst),
    .req(lar_if_inst.req), .we(lar_if_inst.we), .word(lar_if_inst.word),
    .addr(lar_if_inst.addr), .wdata(lar_if_inst.wdata),
    .ack(lar_if_inst.ack), .rdata(lar_if_inst.rdata));
  // Compare and count
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected data exp %h got %h", e, g);
    end
  endtask
  // A wait that runs out ends the run as a failure
  task automatic lim(input logic ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("unexpected wait limit exp 1 got %b", ok);
      summarize();
    end
  endtask
  // Wait for the host to finish, bounded
  task automatic wt;
    for (int n = 0; n < 40 && done !== 1'b1; n++) @(posedge clk) #1;
    lim(done);
    d = data;
  endtask
  // One host read; byte reads keep the low byte only
  task automatic rd(input logic w, input logic [7:0] a);
    wsel = w;
    adr = a;
    start = 1'b1;
    @(posedge clk) #1 start = 1'b0;
    wt();
    if (!w) d = {8'h00, d[7:0]};
  endtask
  // Load a conversion result
  task automatic cv(input logic [15:0] a, input logic [15:0] b);
    v0 = a;
    v1 = b;
    conv = 1'b1;
    @(posedge clk) #1 conv = 1'b0;
  endtask
  task automatic t_reset;
    rd(1, 8'h14); chk(16'h0000, d);
    rd(1, 8'h16); chk(16'h0000, d);
    rd(1, 8'h18); chk(16'h0000, d);
    rd(0, 8'h1E); chk({8'h00, PART_FLAG, 7'h00}, d);
    rd(1, 8'h20); chk(16'h0000, d);
    chk(16'h0000, {15'h0000, busy});
    $display("t_reset done");
  endtask
  task automatic t_pair;
    cv(16'h1234, 16'hABCD);
    rd(1, 8'h14); chk(16'h1234, d);
    rd(1, 8'h16); chk(16'hABCD, d);
    rd(0, 8'h17); chk(16'h00AB, d);
    $display("t_pair done");
  endtask
  // New result lands between low and high read
  task automatic t_shadow;
    wsel = 1'b0;
    adr = 8'h15;
    start = 1'b1;
    @(posedge clk) #1 start = 1'b0;
    chk(16'h0001, {15'h0000, busy});
    for (int n = 0; n < 9 && lar_if_inst.ack !== 1'b1; n++) @(posedge clk) #1;
    lim(lar_if_inst.ack);
    cv(16'h5678, 16'hABCD);
    wt();
    chk(16'h0012, {8'h00, d[7:0]});
    rd(1, 8'h14); chk(16'h5678, d);
    $display("t_shadow done");
  endtask
  // Manual run of 20 cycles, hold, then a short rerun
  task automatic t_manual;
    run = 1'b1;
    repeat (20) @(posedge clk) #1;
    chk(16'h0001, {15'h0000, mbusy});
    run = 1'b0;
    repeat (3) @(posedge clk) #1;
    chk(16'h0000, {15'h0000, mbusy});
    rd(1, 8'h18); chk(16'h000A, d);
    repeat (10) @(posedge clk) #1;
    rd(1, 8'h18); chk(16'h000A, d);
    run = 1'b1;
    repeat (4) @(posedge clk) #1;
    run = 1'b0;
    rd(1, 8'h18); chk(16'h0002, d);
    $display("t_manual done");
  endtask
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    summarize();
  end
  // Main sequence
  initial begin
    {start, wsel, conv, run, adr, v0, v1} = '0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_pair();
    t_shadow();
    t_manual();
    summarize();
  end
endmodule
